// ---- pkg/bpcl_cfg.svh ----
`ifndef BPCL_CFG_SVH
`define BPCL_CFG_SVH

// register offsets on the address pins
`define BPCL_OFS_DATA      2'h0
`define BPCL_OFS_DIR       2'h1
`define BPCL_OFS_CMD       2'h2

// command byte layout
`define BPCL_CMD_CHAIN_HI  2
`define BPCL_CMD_CHAIN_LO  0
`define BPCL_CMD_CHAIN_WE  3
`define BPCL_CMD_RST_PAR   4
`define BPCL_CMD_RST_CTR   5
`define BPCL_CMD_RST_SER   6
`define BPCL_CMD_SIG_SEL   7

// reset values
`define BPCL_DIR_RST       8'h00
`define BPCL_OUT_RST       8'h00
`define BPCL_CHAIN_RST     3'h0
`define BPCL_ZERO_BYTE     8'h00

// chain order codes, first letter highest priority
`define BPCL_CH_SCP        3'h0
`define BPCL_CH_SPC        3'h1
`define BPCL_CH_CSP        3'h2
`define BPCL_CH_CPS        3'h3
`define BPCL_CH_PSC        3'h4
`define BPCL_CH_PCS        3'h5
`define BPCL_CH_NONE_A     3'h6
`define BPCL_CH_NONE_B     3'h7

// port bits taken by serial control signals
`define BPCL_PIN_SYNC_B    1
`define BPCL_PIN_DTR_B     2
`define BPCL_PIN_RTS_B     3
`define BPCL_PIN_RTS_A     4
`define BPCL_PIN_DTR_A     5
`define BPCL_PIN_SYNC_A    6

`endif

// ---- pkg/bpcl_pkg.sv ----
package bpcl_pkg;

  typedef enum logic [1:0] {
    BPCL_UNIT_NONE     = 2'h0,
    BPCL_UNIT_SERIAL   = 2'h1,
    BPCL_UNIT_COUNTER  = 2'h3,
    BPCL_UNIT_PARALLEL = 2'h2
  } bpcl_unit_t;

  typedef struct packed {
    logic       active;
    bpcl_unit_t first;
    bpcl_unit_t second;
    bpcl_unit_t third;
  } bpcl_chain_t;

  typedef struct packed {
    logic serial;
    logic counter;
    logic parallel;
  } bpcl_unit_rst_t;

  typedef struct packed {
    logic dtr_a_n;
    logic dtr_b_n;
    logic rts_a_n;
    logic rts_b_n;
    logic sync_a_n;
    logic sync_a_oe;
    logic sync_b_n;
    logic sync_b_oe;
  } bpcl_serial_ctl_t;

endpackage

// ---- verification/bit_port_and_command_logic_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bpcl_cfg.svh"
module bit_port_and_command_logic_test;
  import bpcl_pkg::*;
  logic             clk, rst, cs_n, io_request_n, rd_n, d_oe, got_oe;
  logic             sync_a_in_n, sync_b_in_n, port_signal_select;
  logic [1:0]       addr;
  logic [7:0]       d_in, d_out, pin_in, pin_out, pin_oe, v, w;
  bpcl_serial_ctl_t serial_ctl;
  bpcl_chain_t      chain;
  bpcl_unit_rst_t   unit_rst, rst_seen;
  int               n_fail, checked, cycles, pulses;
  logic [5:0]       ord [6] = '{6'h1E, 6'h1B, 6'h36, 6'h39, 6'h27, 6'h2D};

  bpcl_top dut (.clk(clk), .rst(rst), .cs_n(cs_n), .io_request_n(io_request_n), .rd_n(rd_n),
    .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .serial_ctl(serial_ctl), .sync_a_in_n(sync_a_in_n), .sync_b_in_n(sync_b_in_n),
    .chain(chain), .unit_rst(unit_rst), .port_signal_select(port_signal_select));
  bpcl_host host (.clk(clk), .cs_n(cs_n), .io_request_n(io_request_n), .rd_n(rd_n),
    .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (unit_rst !== 3'b000) begin
      rst_seen <= rst_seen | unit_rst;
      pulses   <= pulses + 1;
    end
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic t_reset();
    chk(pin_oe, 8'h00, "oe after reset");
    chk({5'h0, unit_rst}, 8'h00, "unit reset idle");
    chk({7'h0, port_signal_select}, 8'h00, "select after reset");
    host.rd(`BPCL_OFS_DIR, v, got_oe);
    chk(v, 8'h00, "dir after reset");
  endtask

  task automatic t_port();
    host.wr(`BPCL_OFS_DIR, 8'h0F);
    host.wr(`BPCL_OFS_DATA, 8'hA5);
    pin_in = 8'h3C;
    chk(pin_oe, 8'h0F, "direction per bit");
    chk(pin_out & 8'h0F, 8'h05, "output latch");
    host.rd(`BPCL_OFS_DATA, v, got_oe);
    chk(v, 8'h35, "mixed read");
    chk({7'h0, got_oe}, 8'h01, "read drive");
    @(negedge clk);
    chk({7'h0, d_oe}, 8'h00, "drive released");
    host.wr(2'h3, 8'hFF);
    pin_in = 8'hC3;
    host.rd(`BPCL_OFS_DATA, v, got_oe);
    chk(v, 8'hC5, "pin level and unmapped write");
    host.rd(`BPCL_OFS_CMD, v, got_oe);
    chk(v, 8'h00, "command read");
  endtask

  task automatic t_chain();
    for (int c = 0; c < 8; c++) begin
      host.wr(`BPCL_OFS_CMD, 8'h08 | 8'(c));
      @(negedge clk);
      chk({7'h0, chain.active}, (c < 6) ? 8'h01 : 8'h00, "chain active");
      if (c < 6) chk({2'h0, chain.first, chain.second, chain.third}, {2'h0, ord[c]}, "chain order");
    end
    host.wr(`BPCL_OFS_CMD, 8'h0B);
  endtask

  task automatic t_unit_rst();
    for (int i = 4; i < 7; i++) begin
      @(negedge clk);
      rst_seen = 3'b000;
      pulses   = 0;
      host.wr(`BPCL_OFS_CMD, (8'h01 << i) | 8'h05);
      repeat (2) @(negedge clk);
      chk({5'h0, rst_seen}, 8'h01 << (i - 4), "unit reset");
      chk(8'(pulses), 8'h01, "one pulse");
      chk({2'h0, chain.first, chain.second, chain.third}, {2'h0, ord[3]}, "chain kept");
    end
    host.rd(`BPCL_OFS_DIR, v, got_oe);
    chk(v, 8'h0F, "port untouched");
  endtask

  // held read keeps its first capture; held command write acts once
  task automatic t_hold();
    rst_seen = 3'b000;
    pulses   = 0;
    pin_in   = 8'h00;
    fork
      host.rd_held(`BPCL_OFS_DATA, 3, v, w, got_oe);
      begin
        repeat (2) @(negedge clk);
        pin_in = 8'hF0;
      end
    join
    chk(v, 8'h05, "held read first");
    chk(w, 8'h05, "held read kept");
    chk({7'h0, got_oe}, 8'h01, "held drive");
    host.wr_held(`BPCL_OFS_CMD, 3, 8'h4B);
    chk({5'h0, rst_seen}, 8'h04, "held command once");
    chk(8'(pulses), 8'h01, "held one pulse");
  endtask

  task automatic t_sel();
    host.wr(`BPCL_OFS_DIR, 8'h81);
    host.wr(`BPCL_OFS_DATA, 8'h01);
    serial_ctl = 8'h9D;
    pin_in = 8'h40;
    host.wr(`BPCL_OFS_CMD, 8'h80);
    @(negedge clk);
    chk({7'h0, port_signal_select}, 8'h01, "select");
    chk(pin_oe, 8'hFF, "serial drive");
    chk(pin_out, 8'h69, "serial map");
    chk({6'h0, sync_a_in_n, sync_b_in_n}, 8'h02, "sync inputs");
    serial_ctl = 8'h62;
    #1;
    chk(pin_oe, 8'hBD, "sync released");
    chk(pin_out & pin_oe, 8'h15, "serial map inverted");
    host.wr(`BPCL_OFS_CMD, 8'h00);
    @(negedge clk);
    chk(pin_oe, 8'h81, "general again");
    chk(pin_out & 8'h81, 8'h01, "general latch");
  endtask

  initial begin
    {n_fail, checked, cycles, pulses} = '0;
    rst_seen   = 3'b000;
    rst        = 1'b1;
    pin_in     = 8'h00;
    serial_ctl = 8'hFF;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_port();
    t_chain();
    t_unit_rst();
    t_hold();
    t_sel();
    summarize();
  end
endmodule
`default_nettype wire

// ---- verification/bpcl_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// cpu side: strobes change on falling edges, held across the taking edge
module bpcl_host (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            io_request_n,
  output logic            rd_n,
  output logic [1:0]      addr,
  output logic [7:0]      d_in,
  input  wire logic [7:0] d_out,
  input  wire logic       d_oe
);
  initial begin
    {cs_n, io_request_n, rd_n} = 3'b111;
    addr = 2'h0;
    d_in = 8'h00;
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    wr_held(a, 1, d);
  endtask

  // access held across n taking edges; only the first may act
  task automatic wr_held(input logic [1:0] a, input int n, input logic [7:0] d);
    @(negedge clk);
    {cs_n, io_request_n, rd_n} = 3'b001;
    addr = a;
    d_in = d;
    repeat (n) @(negedge clk);
    {cs_n, io_request_n, rd_n} = 3'b111;
    addr = ~a;
    d_in = ~d;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    {cs_n, io_request_n, rd_n} = 3'b000;
    addr = a;
    @(negedge clk);
    d = d_out;
    oe = d_oe;
    {cs_n, io_request_n, rd_n} = 3'b111;
    addr = ~a;
  endtask

  task automatic rd_held(input logic [1:0] a, input int n, output logic [7:0] d,
                         output logic [7:0] d_last, output logic oe);
    @(negedge clk);
    {cs_n, io_request_n, rd_n} = 3'b000;
    addr = a;
    @(negedge clk);
    d = d_out;
    repeat (n - 1) @(negedge clk);
    d_last = d_out;
    oe = d_oe;
    {cs_n, io_request_n, rd_n} = 3'b111;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// ---- verilog/bpcl_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bpcl_cfg.svh"

module bpcl_top #(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 2
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      cs_n,
  input  wire logic                      io_request_n,
  input  wire logic                      rd_n,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [WIDTH-1:0]          d_in,
  output logic      [WIDTH-1:0]          d_out,
  output logic                           d_oe,
  input  wire logic [WIDTH-1:0]          pin_in,
  output logic      [WIDTH-1:0]          pin_out,
  output logic      [WIDTH-1:0]          pin_oe,
  input  wire bpcl_pkg::bpcl_serial_ctl_t serial_ctl,
  output logic                           sync_a_in_n,
  output logic                           sync_b_in_n,
  output bpcl_pkg::bpcl_chain_t          chain,
  output bpcl_pkg::bpcl_unit_rst_t       unit_rst,
  output logic                           port_signal_select
);
  import bpcl_pkg::*;

  logic [WIDTH-1:0] dir_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] rd_mux;
  logic [WIDTH-1:0] d_out_ff;
  logic             d_oe_ff;
  logic             rd_seen_ff;
  logic             wr_seen_ff;
  logic [2:0]       chain_code_ff;
  logic             sel_ff;
  bpcl_unit_rst_t   unit_rst_ff;
  bpcl_chain_t      chain_ff;
  logic             rd_cyc;
  logic             wr_cyc;
  logic             rd_go;
  logic             wr_go;
  logic             cmd_go;

  // bus decode; one action per access
  assign rd_cyc = !io_request_n && !cs_n && !rd_n;
  assign wr_cyc = !io_request_n && !cs_n && rd_n;
  assign rd_go  = rd_cyc && !rd_seen_ff;
  assign wr_go  = wr_cyc && !wr_seen_ff;
  assign cmd_go = wr_go && (addr == `BPCL_OFS_CMD);

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_seen_ff <= 1'b0;
      wr_seen_ff <= 1'b0;
    end else begin
      rd_seen_ff <= rd_cyc;
      wr_seen_ff <= wr_cyc;
    end
  end

  // per-line read source
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_line
      assign rd_mux[gi] = dir_ff[gi] ? out_ff[gi] : pin_in[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_ff <= `BPCL_DIR_RST;
      out_ff <= `BPCL_OUT_RST;
    end else if (wr_go) begin
      if (addr == `BPCL_OFS_DIR)
        dir_ff <= d_in;
      if (addr == `BPCL_OFS_DATA)
        out_ff <= d_in;
    end
  end

  // read capture and bus drive
  always_ff @(posedge clk) begin
    if (rst) begin
      d_out_ff <= `BPCL_ZERO_BYTE;
      d_oe_ff  <= 1'b0;
    end else begin
      d_oe_ff <= rd_cyc;
      if (rd_go) begin
        case (addr)
          `BPCL_OFS_DATA: d_out_ff <= rd_mux;
          `BPCL_OFS_DIR:  d_out_ff <= dir_ff;
          default:        d_out_ff <= `BPCL_ZERO_BYTE;
        endcase
      end
    end
  end

  assign d_out = d_out_ff;
  assign d_oe  = d_oe_ff;

  // command register
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_code_ff <= `BPCL_CHAIN_RST;
      sel_ff        <= 1'b0;
    end else if (cmd_go) begin
      if (d_in[`BPCL_CMD_CHAIN_WE])
        chain_code_ff <= d_in[`BPCL_CMD_CHAIN_HI:`BPCL_CMD_CHAIN_LO];
      sel_ff <= d_in[`BPCL_CMD_SIG_SEL];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      unit_rst_ff <= '0;
    end else begin
      unit_rst_ff.serial   <= cmd_go && d_in[`BPCL_CMD_RST_SER];
      unit_rst_ff.counter  <= cmd_go && d_in[`BPCL_CMD_RST_CTR];
      unit_rst_ff.parallel <= cmd_go && d_in[`BPCL_CMD_RST_PAR];
    end
  end

  // chain order decode
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_ff <= '0;
    end else begin
      chain_ff.active <= 1'b1;
      case (chain_code_ff)
        `BPCL_CH_SCP: begin
          chain_ff.first  <= BPCL_UNIT_SERIAL;
          chain_ff.second <= BPCL_UNIT_COUNTER;
          chain_ff.third  <= BPCL_UNIT_PARALLEL;
        end
        `BPCL_CH_SPC: begin
          chain_ff.first  <= BPCL_UNIT_SERIAL;
          chain_ff.second <= BPCL_UNIT_PARALLEL;
          chain_ff.third  <= BPCL_UNIT_COUNTER;
        end
        `BPCL_CH_CSP: begin
          chain_ff.first  <= BPCL_UNIT_COUNTER;
          chain_ff.second <= BPCL_UNIT_SERIAL;
          chain_ff.third  <= BPCL_UNIT_PARALLEL;
        end
        `BPCL_CH_CPS: begin
          chain_ff.first  <= BPCL_UNIT_COUNTER;
          chain_ff.second <= BPCL_UNIT_PARALLEL;
          chain_ff.third  <= BPCL_UNIT_SERIAL;
        end
        `BPCL_CH_PSC: begin
          chain_ff.first  <= BPCL_UNIT_PARALLEL;
          chain_ff.second <= BPCL_UNIT_SERIAL;
          chain_ff.third  <= BPCL_UNIT_COUNTER;
        end
        `BPCL_CH_PCS: begin
          chain_ff.first  <= BPCL_UNIT_PARALLEL;
          chain_ff.second <= BPCL_UNIT_COUNTER;
          chain_ff.third  <= BPCL_UNIT_SERIAL;
        end
        default: begin
          chain_ff.active <= 1'b0;
          chain_ff.first  <= BPCL_UNIT_NONE;
          chain_ff.second <= BPCL_UNIT_NONE;
          chain_ff.third  <= BPCL_UNIT_NONE;
        end
      endcase
    end
  end

  assign chain              = chain_ff;
  assign unit_rst           = unit_rst_ff;
  assign port_signal_select = sel_ff;
  assign sync_a_in_n        = pin_in[`BPCL_PIN_SYNC_A];
  assign sync_b_in_n        = pin_in[`BPCL_PIN_SYNC_B];

  // pin mux; bits 0 and 7 always general
  always_comb begin
    pin_out = out_ff;
    pin_oe  = dir_ff;
    if (sel_ff) begin
      pin_out[`BPCL_PIN_DTR_A]  = serial_ctl.dtr_a_n;
      pin_oe[`BPCL_PIN_DTR_A]   = 1'b1;
      pin_out[`BPCL_PIN_DTR_B]  = serial_ctl.dtr_b_n;
      pin_oe[`BPCL_PIN_DTR_B]   = 1'b1;
      pin_out[`BPCL_PIN_RTS_A]  = serial_ctl.rts_a_n;
      pin_oe[`BPCL_PIN_RTS_A]   = 1'b1;
      pin_out[`BPCL_PIN_RTS_B]  = serial_ctl.rts_b_n;
      pin_oe[`BPCL_PIN_RTS_B]   = 1'b1;
      pin_out[`BPCL_PIN_SYNC_A] = serial_ctl.sync_a_n;
      pin_oe[`BPCL_PIN_SYNC_A]  = serial_ctl.sync_a_oe;
      pin_out[`BPCL_PIN_SYNC_B] = serial_ctl.sync_b_n;
      pin_oe[`BPCL_PIN_SYNC_B]  = serial_ctl.sync_b_oe;
    end
  end
  // the port has no ready, strobe or interrupt signals at all

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_dir_write;
    wr_go && addr == `BPCL_OFS_DIR |=> dir_ff == $past(d_in) && pin_oe[0] == $past(d_in[0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_out_latch;
    wr_go && addr == `BPCL_OFS_DATA |=> out_ff == $past(d_in);
  endproperty
  a_out_latch: assert property (p_out_latch) else $error("output latch not loaded");

  property p_read_input;
    rd_go && addr == `BPCL_OFS_DATA |=> d_oe
      && d_out == (($past(dir_ff) & $past(out_ff)) | (~$past(dir_ff) & $past(pin_in)));
  endproperty
  a_read_input: assert property (p_read_input) else $error("input line read wrong");

  property p_read_drive;
    rd_go && addr == `BPCL_OFS_DATA ##1 rd_cyc |=> d_oe && $stable(d_out);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not held");

  property p_read_release;
    !rd_cyc |=> !d_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus driven outside read");

  property p_chain_update;
    cmd_go && d_in[`BPCL_CMD_CHAIN_WE] |=> chain_code_ff == $past(d_in[`BPCL_CMD_CHAIN_HI:`BPCL_CMD_CHAIN_LO]);
  endproperty
  a_chain_update: assert property (p_chain_update) else $error("chain order not taken");

  property p_chain_hold;
    !(cmd_go && d_in[`BPCL_CMD_CHAIN_WE]) |=> $stable(chain_code_ff);
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain order changed");

  property p_chain_none;
    chain_code_ff == `BPCL_CH_NONE_A |=> !chain.active && chain.first == BPCL_UNIT_NONE;
  endproperty
  a_chain_none: assert property (p_chain_none) else $error("chain not emptied");

  property p_unit_reset;
    cmd_go && d_in[`BPCL_CMD_RST_SER] |=> unit_rst.serial ##1 !unit_rst.serial || cmd_go;
  endproperty
  a_unit_reset: assert property (p_unit_reset) else $error("serial reset pulse wrong");

  property p_after_reset;
    $past(rst) |-> dir_ff == `BPCL_DIR_RST && !sel_ff;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("reset state wrong");

  property p_pin_map;
    sel_ff |-> pin_out[`BPCL_PIN_DTR_A] == serial_ctl.dtr_a_n && pin_out[`BPCL_PIN_RTS_B] == serial_ctl.rts_b_n
               && pin_out[`BPCL_PIN_SYNC_B] == serial_ctl.sync_b_n && pin_oe[`BPCL_PIN_DTR_B];
  endproperty
  a_pin_map: assert property (p_pin_map) else $error("serial signal mapping wrong");

  property p_gp_lines;
    pin_oe[0] == dir_ff[0] && pin_out[WIDTH-1] == out_ff[WIDTH-1];
  endproperty
  a_gp_lines: assert property (p_gp_lines) else $error("general line disturbed");

  c_read: cover property (rd_go && addr == `BPCL_OFS_DATA ##1 d_oe);
  c_chain: cover property (cmd_go && d_in[`BPCL_CMD_CHAIN_WE] ##1 chain_code_ff == `BPCL_CH_PCS);
  c_select: cover property (cmd_go && d_in[`BPCL_CMD_SIG_SEL] ##1 sel_ff);
  c_reset: cover property (unit_rst.counter);

endmodule
`default_nettype wire
